// >>> src/ebc_pkg.sv
// shared constants and types for the external bus controller
package ebc_pkg;

  localparam int unsigned NWIN = 5;
  localparam int unsigned ADDR_W = 24;

  // register byte offsets
  localparam logic [7:0] OFS_GCR  = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TCFG = 8'h10;
  localparam logic [7:0] OFS_FCFG = 8'h30;
  localparam logic [7:0] OFS_ASEL = 8'h50;

  // global configuration fields
  localparam int GCR_EXT = 0;
  localparam int GCR_AW  = 4;
  localparam logic [4:0] AW_MAX = 5'd24;

  // window timing fields, each phase lasts field+1 reference clocks
  localparam int T_AB     = 0;
  localparam int T_C      = 2;
  localparam int T_D      = 4;
  localparam int T_E      = 5;
  localparam int T_F      = 10;
  localparam int T_RDYEN  = 12;
  localparam int T_RDYPOL = 13;
  localparam logic [15:0] TCFG_RST = 16'h0fff;

  // window function fields
  localparam int F_EN    = 0;
  localparam int F_BUS16 = 1;
  localparam int F_MUX   = 2;
  localparam int F_INT   = 3;
  localparam int F_CSEN  = 4;
  localparam logic [7:0] FCFG0_RST = 8'h13;

  // window address select fields
  localparam int A_SIZE = 0;
  localparam int A_BASE = 4;

  // timing: reference clock is the system clock divided by two
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned REF_NS = 8;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_AB   = 3'b001,
    PH_C    = 3'b010,
    PH_D    = 3'b011,
    PH_E    = 3'b100,
    PH_F    = 3'b101
  } ebc_phase_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebc_req_t;

  typedef struct packed {
    logic        ref_clk;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        bhe_n;
    logic [4:0]  cs_n;
    logic [23:0] addr;
    logic [23:0] addr_oe;
    logic [15:0] ad_o;
    logic [15:0] ad_oe;
  } ebc_pins_t;

  localparam ebc_pins_t PINS_RST = '{ref_clk: 1'b0, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                                     bhe_n: 1'b1, cs_n: 5'h1f, addr: 24'h0,
                                     addr_oe: 24'h0, ad_o: 16'h0, ad_oe: 16'h0};

  typedef struct packed {
    logic        req;
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebc_ipb_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ebc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ebc_apb_rsp_t;

endpackage : ebc_pkg

// >>> src/ebc_win_dec.sv
// address window decoder with fixed priority
module ebc_win_dec (
  // access address
  input  wire logic [23:0]      addr,
  // window selects and enables, index 0 is window one
  input  wire logic [3:0][15:0] asel,
  input  wire logic [3:0]       en,
  // per window hits and the chosen window
  output logic      [3:0]       hits,
  output logic      [2:0]       win
);
  import ebc_pkg::*;

  function automatic logic win_hit(input logic [23:0] a, input logic [15:0] s);
    logic [11:0] mask;
    mask = 12'hfff << s[A_SIZE +: 4];
    win_hit = ((a[23:12] ^ s[A_BASE +: 12]) & mask) == 12'h000;
  endfunction : win_hit

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hits[i] = en[i] && win_hit(addr, asel[i]);
    end
    // four beats three, two beats one; upper pair ranks above lower pair
    if (hits[3]) win = 3'd4; // R10
    else if (hits[2]) win = 3'd3;
    else if (hits[1]) win = 3'd2; // R10
    else if (hits[0]) win = 3'd1;
    else win = 3'd0; // R11
  end

endmodule : ebc_win_dec

// >>> src/ebc_ctrl.sv
// external bus controller: apb registers, window select and bus cycle sequencer
//
// The address map and the APB interface to the registers were decided locally.

// Notes on behaviour
// R1: single-chip setting or external bus setting chosen by a global bit.
// R2: external address width programmable from zero to twenty-four bits.
// R3: each window selects an eight or sixteen bit data bus.
// R4: each window selects multiplexed or demultiplexed cycles.
// R5: demultiplexed cycles drive low address bits on separate address lines.
// R6: unused upper address lines are released, limiting reachable space.
// R7: timing and function registers set each window's cycle shape.
// R8: ready input stretches accesses; its active level is programmable.
// R9: four address windows with their own settings, plus a default.
// R10: window four beats three, window two beats one.
// R11: accesses outside every window use the default window zero.
// R12: the active window, default included, may drive its chip select.
// R13: all bus outputs change with the reference clock rising edge.
// R14: width and multiplexing switch per access with the chosen window.
// R15: internal peripheral bus accesses run the same phase sequence.
// R16: any address, reserved or not, becomes an ordinary bus cycle.
// R17: every address may be accessed as a byte or a 16-bit word.
// R18: each cycle runs five phases with programmed lengths.
// R19: only the access phase may be stretched by ready.
// R20: ready sampled on reference rising edges; access ends after active level.
// R21: single-chip setting drives no external cycle and releases the lines.
module ebc_ctrl (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  // register bus
  input  wire ebc_pkg::ebc_apb_req_t APB_REQ,
  output ebc_pkg::ebc_apb_rsp_t      APB_RSP,
  // core access port
  input  wire ebc_pkg::ebc_req_t     CORE_REQ,
  output logic               CORE_DONE,
  output logic [15:0]        CORE_RDATA,
  // external bus pins
  output ebc_pkg::ebc_pins_t         BUS_PINS,
  input  wire logic [15:0]   AD_LINES,
  input  wire logic          READY_PIN,
  // internal peripheral bus
  output ebc_pkg::ebc_ipb_t          IPB_CMD,
  input  wire logic [15:0]   IPB_RDATA,
  input  wire logic          IPB_READY
);
  import ebc_pkg::*;

  typedef struct packed {
    logic                  ext;
    logic [4:0]            aw;
    logic [NWIN-1:0][15:0] tcfg;
    logic [NWIN-1:0][7:0]  fcfg;
    logic [3:0][15:0]      asel;
    ebc_phase_t            ph;
    logic [4:0]            cnt;
    logic [2:0]            win;
    ebc_req_t              cur;
    logic                  second;
    logic [15:0]           rbuf;
    logic                  rdy_s1;
    logic                  rdy_s2;
    logic [15:0]           ad_s1;
    logic [15:0]           ad_s2;
    ebc_pins_t             pins;
    ebc_ipb_t              ipb;
    ebc_apb_rsp_t          apb;
    logic                  done;
    logic [15:0]           rdata;
  } ebc_st_t;

  ebc_st_t     q;
  ebc_st_t     d;
  logic [3:0]  dec_hits;
  logic [2:0]  dec_win;
  logic        tick;
  logic [15:0] tc;
  logic [7:0]  fc;
  logic [7:0]  fn;
  logic        fint;
  logic        rdy_ok;
  logic [15:0] src;
  logic [15:0] dat;
  logic [23:0] baddr;
  logic        cmd;
  logic        reg_hit;
  logic [31:0] rd_val;

  function automatic logic [7:0] ebc_ofs(input logic [7:0] base, input int i);
    ebc_ofs = base + 8'(4 * i);
  endfunction : ebc_ofs

  function automatic logic [23:0] ebc_amask(input logic [4:0] aw);
    ebc_amask = ~(24'hff_ffff << aw);
  endfunction : ebc_amask

  function automatic logic [4:0] ebc_plen(input ebc_phase_t p, input logic [15:0] t);
    case (p)
      PH_AB:   ebc_plen = {3'b000, t[T_AB +: 2]};
      PH_C:    ebc_plen = {3'b000, t[T_C +: 2]};
      PH_D:    ebc_plen = {4'b0000, t[T_D]};
      PH_E:    ebc_plen = t[T_E +: 5];
      PH_F:    ebc_plen = {3'b000, t[T_F +: 2]};
      default: ebc_plen = 5'd0;
    endcase
  endfunction : ebc_plen

  ebc_win_dec u_dec (
    .addr (CORE_REQ.addr),
    .asel (q.asel),
    .en   ({q.fcfg[4][F_EN], q.fcfg[3][F_EN], q.fcfg[2][F_EN], q.fcfg[1][F_EN]}),
    .hits (dec_hits),
    .win  (dec_win)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    // pin inputs pass two flops before use
    d.rdy_s1 = READY_PIN;
    d.rdy_s2 = q.rdy_s1;
    d.ad_s1 = AD_LINES;
    d.ad_s2 = q.ad_s1;

    // register read mux, unmapped reads answer zero with an error
    reg_hit = 1'b0;
    rd_val = 32'h0;
    if (APB_REQ.paddr == OFS_GCR) begin
      reg_hit = 1'b1;
      rd_val[GCR_EXT] = q.ext;
      rd_val[GCR_AW +: 5] = q.aw;
    end
    if (APB_REQ.paddr == OFS_STAT) begin
      reg_hit = 1'b1;
      rd_val[2:0] = q.ph;
      rd_val[6:4] = q.win;
      rd_val[8] = q.second;
      rd_val[9] = q.rdy_s2;
    end
    for (int i = 0; i < NWIN; i++) begin
      if (APB_REQ.paddr == ebc_ofs(OFS_TCFG, i)) begin
        reg_hit = 1'b1;
        rd_val[15:0] = q.tcfg[i];
      end
      if (APB_REQ.paddr == ebc_ofs(OFS_FCFG, i)) begin
        reg_hit = 1'b1;
        rd_val[7:0] = q.fcfg[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (APB_REQ.paddr == ebc_ofs(OFS_ASEL, i)) begin
        reg_hit = 1'b1;
        rd_val[15:0] = q.asel[i];
      end
    end

    // one wait state: answer is prepared in the first access cycle
    d.apb.pready = 1'b0;
    if (APB_REQ.psel && APB_REQ.penable && !q.apb.pready) begin
      d.apb.pready = 1'b1;
      d.apb.pslverr = !reg_hit;
      d.apb.prdata = rd_val;
    end
    if (APB_REQ.psel && APB_REQ.penable && q.apb.pready && APB_REQ.pwrite) begin
      if (APB_REQ.paddr == OFS_GCR) begin
        d.ext = APB_REQ.pwdata[GCR_EXT]; // R1
        d.aw = (APB_REQ.pwdata[GCR_AW +: 5] > AW_MAX) ? AW_MAX
                                                      : APB_REQ.pwdata[GCR_AW +: 5]; // R2
      end
      for (int i = 0; i < NWIN; i++) begin
        if (APB_REQ.paddr == ebc_ofs(OFS_TCFG, i)) d.tcfg[i] = APB_REQ.pwdata[15:0]; // R7
        if (APB_REQ.paddr == ebc_ofs(OFS_FCFG, i)) d.fcfg[i] = APB_REQ.pwdata[7:0]; // R7
      end
      for (int i = 0; i < 4; i++) begin
        if (APB_REQ.paddr == ebc_ofs(OFS_ASEL, i)) d.asel[i] = APB_REQ.pwdata[15:0]; // R9
      end
    end

    // reference clock and the sequencer step on its rising edge
    d.pins.ref_clk = !q.pins.ref_clk; // R13
    tick = !q.pins.ref_clk;
    tc = q.tcfg[q.win];
    fc = q.fcfg[q.win];
    fint = fc[F_INT];
    rdy_ok = !tc[T_RDYEN] || (fint ? IPB_READY : (q.rdy_s2 == tc[T_RDYPOL])); // R8 R20
    src = fint ? IPB_RDATA : q.ad_s2;
    if (tick) begin
      case (q.ph)
        PH_IDLE: begin
          // done is never high on a tick, so this guard never blocks a request
          if (CORE_REQ.valid && !q.done) begin
            d.cur = CORE_REQ; // R16 R17
            d.win = dec_win; // R9 R11
            d.second = 1'b0;
            d.rbuf = 16'h0;
            if (!q.ext && !q.fcfg[dec_win][F_INT]) begin
              d.done = 1'b1; // R21
              d.rdata = 16'h0;
            end else begin
              d.ph = PH_AB; // R14 R15
              d.cnt = ebc_plen(PH_AB, q.tcfg[dec_win]);
            end
          end
        end
        default: begin
          if (q.cnt != 5'd0) begin
            d.cnt = q.cnt - 5'd1; // R18
          end else begin
            case (q.ph)
              PH_AB: d.ph = PH_C; // R18
              PH_C:  d.ph = PH_D;
              PH_D:  d.ph = PH_E;
              PH_E: begin
                if (rdy_ok) begin // R19 R20
                  d.ph = PH_F;
                  if (!fc[F_BUS16] && !fint) begin
                    if (q.second) d.rbuf[15:8] = src[7:0];
                    else d.rbuf[7:0] = src[7:0];
                  end else if (q.cur.word) begin
                    d.rbuf = src;
                  end else begin
                    d.rbuf[7:0] = q.cur.addr[0] ? src[15:8] : src[7:0]; // R17
                  end
                end
              end
              PH_F: begin
                // a word on an eight bit bus takes a second cycle at addr+1
                if (q.cur.word && !fc[F_BUS16] && !fint && !q.second) begin
                  d.second = 1'b1; // R3 R17
                  d.ph = PH_AB;
                end else begin
                  d.ph = PH_IDLE;
                  d.done = 1'b1;
                  d.rdata = d.rbuf;
                end
              end
              default: d.ph = PH_IDLE;
            endcase
            if (d.ph != q.ph) d.cnt = ebc_plen(d.ph, tc);
          end
        end
      endcase
    end

    // pin drive follows the next phase so pins and state stay aligned
    fn = q.fcfg[d.win];
    baddr = d.cur.addr + {23'h0, d.second};
    cmd = (d.ph == PH_D) || (d.ph == PH_E);
    if (fn[F_BUS16]) dat = d.cur.word ? d.cur.wdata : {2{d.cur.wdata[7:0]}};
    else dat = {8'h00, d.second ? d.cur.wdata[15:8] : d.cur.wdata[7:0]};
    d.pins.ale = PINS_RST.ale;
    d.pins.rd_n = PINS_RST.rd_n;
    d.pins.wr_n = PINS_RST.wr_n;
    d.pins.bhe_n = PINS_RST.bhe_n;
    d.pins.cs_n = PINS_RST.cs_n;
    d.pins.addr = PINS_RST.addr;
    d.pins.addr_oe = PINS_RST.addr_oe;
    d.pins.ad_o = PINS_RST.ad_o;
    d.pins.ad_oe = PINS_RST.ad_oe;
    if (d.ph != PH_IDLE && !fn[F_INT]) begin
      d.pins.cs_n[d.win] = !fn[F_CSEN]; // R12
      d.pins.ale = (d.ph == PH_AB);
      d.pins.addr = baddr & ebc_amask(q.aw); // R2 R6
      d.pins.addr_oe = fn[F_MUX] ? (ebc_amask(q.aw) & 24'hff_0000)
                                 : ebc_amask(q.aw); // R4 R5 R6
      d.pins.bhe_n = !(fn[F_BUS16] && (d.cur.word || baddr[0])); // R17
      d.pins.rd_n = !(cmd && !d.cur.write);
      d.pins.wr_n = !(cmd && d.cur.write);
      if (fn[F_MUX] && d.ph == PH_AB) begin
        d.pins.ad_o = baddr[15:0]; // R4
        d.pins.ad_oe = 16'hffff;
      end else if (d.cur.write && d.ph != PH_AB) begin
        d.pins.ad_o = dat;
        d.pins.ad_oe = fn[F_BUS16] ? 16'hffff : 16'h00ff; // R3
      end
    end
    d.ipb.req = (d.ph != PH_IDLE) && fn[F_INT] && cmd; // R15
    d.ipb.write = d.cur.write;
    d.ipb.word = d.cur.word;
    d.ipb.addr = d.cur.addr;
    d.ipb.wdata = d.cur.wdata;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q <= '0;
      q.pins <= PINS_RST;
      q.tcfg <= {NWIN{TCFG_RST}};
      q.fcfg[0] <= FCFG0_RST;
    end else begin
      q <= d;
    end
  end

  assign APB_RSP = q.apb;
  assign CORE_DONE = q.done;
  assign CORE_RDATA = q.rdata;
  assign BUS_PINS = q.pins;
  assign IPB_CMD = q.ipb;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_single_chip_quiet: assert property ( // R21
    (q.ph == PH_IDLE && !q.ext) |=> (q.pins.addr_oe == 24'h0 && q.pins.ad_oe == 16'h0))
    else $error("external lines driven in single-chip setting");

  a_ref_toggles: assert property ( // R13
    !$past(SYS_RST) |-> (q.pins.ref_clk != $past(q.pins.ref_clk))
      ##1 (q.pins.ref_clk != $past(q.pins.ref_clk)))
    else $error("reference clock stopped toggling");

  a_phase_on_rise: assert property ( // R13
    (q.ph != $past(q.ph)) |-> q.pins.ref_clk)
    else $error("phase changed away from reference rising edge");

  a_phase_order: assert property ( // R18
    (q.ph == PH_C) |-> ($past(q.ph) == PH_AB || $past(q.ph) == PH_C))
    else $error("phase C not entered from AB");

  a_ready_hold: assert property ( // R20
    (q.ph == PH_E && tick && q.cnt == 5'd0 && !rdy_ok) |=> q.ph == PH_E [*2])
    else $error("access phase left without ready");

  a_only_e_waits: assert property ( // R19
    (q.ph inside {PH_AB, PH_C, PH_D, PH_F} && tick && q.cnt == 5'd0) |=> q.ph != $past(q.ph))
    else $error("non-access phase stretched");

  a_cs_window: assert property ( // R12
    (q.ph != PH_IDLE && $stable(q.fcfg) && !fc[F_INT] && fc[F_CSEN])
      |-> q.pins.cs_n == ~(5'b00001 << q.win))
    else $error("chip select does not match active window");

  a_width_mask: assert property ( // R6
    (q.pins.addr_oe & ~ebc_amask($past(q.aw))) == 24'h0)
    else $error("address line driven above programmed width");

  a_win_prio: assert property ( // R10
    (dec_hits[3] |-> dec_win == 3'd4) and (dec_hits == 4'b0011 |-> dec_win == 3'd2))
    else $error("window priority wrong");

  a_win_default: assert property ( // R11
    (dec_hits == 4'b0000) |-> dec_win == 3'd0)
    else $error("default window not chosen");

  a_bus8_lanes: assert property ( // R3
    (q.ph inside {PH_C, PH_D, PH_E, PH_F} && !fc[F_BUS16] && !fc[F_INT] && $stable(q.fcfg))
      |-> q.pins.ad_oe[15:8] == 8'h00)
    else $error("upper data lanes driven on eight bit bus");

  c_mux_write: cover property (q.ph == PH_D && fc[F_MUX] && q.cur.write);
  c_ready_wait: cover property (q.ph == PH_E && q.cnt == 5'd0 && !rdy_ok ##2 q.ph == PH_F);
  c_two_byte_word: cover property (q.second && q.ph == PH_F ##2 q.done);
  c_internal_bus: cover property (q.ipb.req && q.cur.write == 1'b0);

endmodule : ebc_ctrl

// >>> test/ebc_mem_model.sv
// behavioural external memory with a programmable ready answer
module ebc_mem_model (
  // clock and bus pins
  input  wire logic             clk,
  input  wire ebc_pkg::ebc_pins_t pins,
  input  wire logic [15:0]      ad_wire,
  // ready behaviour
  input  wire logic             rdy_pol,
  input  wire logic [3:0]       rdy_wait,
  // answers
  output logic      [15:0]      ad_out,
  output logic                  ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebc_pkg::*;

  logic [7:0] mem [256];
  logic [7:0] a_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  wire  [7:0] ae = {a_q[7:1], 1'b0};
  wire        idle = pins.rd_n && pins.wr_n;

  initial begin
    ad_out = 16'h0000;
    ready = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  always @(posedge clk) begin
    // multiplexed cycles carry the address on the shared lines
    if (pins.ale) a_q <= pins.addr_oe[0] ? pins.addr[7:0] : ad_wire[7:0];
    if (!pins.wr_n && !pins.bhe_n) mem[ae | 8'h01] <= ad_wire[15:8];
    if (!pins.wr_n && (!a_q[0] || pins.bhe_n)) mem[a_q] <= ad_wire[7:0];
    // released lines flip so a stale value never reads as good data
    if (!pins.rd_n) ad_out <= {mem[ae | 8'h01], (a_q[0] && pins.bhe_n) ? mem[a_q] : mem[ae]};
    else ad_out <= ~ad_out;
    if (idle) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    ready <= (!idle && cnt_q >= rdy_wait) ? rdy_pol : !rdy_pol;
  end
endmodule : ebc_mem_model

// >>> test/ebc_ctrl_test.sv
// self-checking bench for the external bus controller
module ebc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ebc_pkg::*;

  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  ebc_apb_req_t apb_q = '0;
  ebc_apb_rsp_t apb_rsp;
  ebc_req_t     core_q = '0;
  logic         core_done;
  logic [15:0]  core_rdata;
  ebc_pins_t    pins;
  ebc_ipb_t     ipb_cmd;
  logic [15:0]  ipb_rdata = 16'h5a3c;
  logic         ipb_ready = 1'b0;
  logic [15:0]  mem_ad;
  logic [15:0]  ad_wire;
  logic         rdy;
  logic         rdy_pol = 1'b0;
  logic [3:0]   rdy_wait = 4'h0;
  int           err_count = 0;
  int           n_checks = 0;
  int           ale_n = 0;
  int           lat = 0;
  int           bad = 0;
  logic [4:0]   cs_and = 5'h1f;
  logic [23:0]  oe_or = 24'h0;
  logic [23:0]  ipb_a = 24'h0;
  logic [15:0]  ipb_w = 16'h0;
  logic [7:0]   last_q = 8'h7f;
  logic [31:0]  r;
  logic         e;
  logic [15:0]  q;

  always #2 clk = ~clk;
  assign ad_wire = (pins.ad_o & pins.ad_oe) | (mem_ad & ~pins.ad_oe);

  ebc_ctrl dut (.CLK(clk), .SYS_RST(sys_rst), .APB_REQ(apb_q), .APB_RSP(apb_rsp),
    .CORE_REQ(core_q), .CORE_DONE(core_done), .CORE_RDATA(core_rdata), .BUS_PINS(pins),
    .AD_LINES(ad_wire), .READY_PIN(rdy), .IPB_CMD(ipb_cmd), .IPB_RDATA(ipb_rdata),
    .IPB_READY(ipb_ready));
  ebc_mem_model far (.clk(clk), .pins(pins), .ad_wire(ad_wire), .rdy_pol(rdy_pol),
    .rdy_wait(rdy_wait), .ad_out(mem_ad), .ready(rdy));

  // bus watcher: strobes may only move with a reference clock rise
  always @(posedge clk) begin
    // level answer keeps the sample at every reference rise deterministic
    ipb_ready <= ipb_cmd.req;
    last_q <= {pins.ale, pins.rd_n, pins.wr_n, pins.cs_n};
    if (!sys_rst && {pins.ale, pins.rd_n, pins.wr_n, pins.cs_n} != last_q && !pins.ref_clk)
      bad <= bad + 1;
    if (ipb_cmd.req) ipb_a <= ipb_cmd.addr;
    if (ipb_cmd.req && ipb_cmd.write && ipb_cmd.word) ipb_w <= ipb_cmd.wdata;
    if (!core_q.valid) begin
      ale_n <= 0;
      cs_and <= 5'h1f;
      oe_or <= 24'h0;
    end else begin
      ale_n <= ale_n + int'(pins.ale && !last_q[7]);
      cs_and <= cs_and & pins.cs_n;
      oe_or <= oe_or | pins.addr_oe;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize;
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic hang;
    err_count++;
    summarize();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (i == 20) hang();
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_q <= '0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rdc

  task automatic core(input logic w, input logic wd, input logic [23:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    core_q <= '{valid: 1'b1, write: w, word: wd, addr: a, wdata: d};
    for (lat = 1; lat < 300; lat++) begin
      @(posedge clk);
      if (core_done === 1'b1) break;
    end
    if (lat == 300) hang();
    q = core_rdata;
    core_q.valid <= 1'b0;
  endtask : core

  // n is the number of reference clocks the whole access should take
  task automatic lat_chk(input int n);
    chk(lat >= 2 * n + 2 && lat <= 2 * n + 3, 1);
  endtask : lat_chk

  task automatic t_reset;
    chk(pins.cs_n, 5'h1f);
    chk(pins.addr_oe | pins.ad_oe, 32'h0);
    rdc(OFS_GCR, 32'h0);
    rdc(OFS_STAT, 32'h200);
    rdc(OFS_TCFG, 32'h0fff);
    rdc(OFS_TCFG + 8'h10, 32'h0fff);
    rdc(OFS_FCFG, 32'h13);
    rdc(OFS_FCFG + 8'h08, 32'h0);
    rdc(OFS_ASEL + 8'h0c, 32'h0);
    rdc(8'hfc, 32'h0);
    chk(e, 1'b1);
  endtask : t_reset

  task automatic t_single;
    core(1'b0, 1'b1, 24'h000100, 16'h0);
    chk(q, 16'h0);
    chk(ale_n, 0);
    chk(cs_and, 5'h1f);
  endtask : t_single

  task automatic t_demux;
    apb(1'b1, OFS_GCR, 32'h1f1);
    rdc(OFS_GCR, 32'h181);
    apb(1'b1, OFS_GCR, 32'h101);
    apb(1'b1, OFS_TCFG, 32'h0);
    core(1'b1, 1'b1, 24'h000010, 16'ha55a);
    lat_chk(5);
    chk(cs_and, 5'h1e);
    chk(oe_or, 24'h00ffff);
    core(1'b0, 1'b1, 24'h000010, 16'h0);
    chk(q, 16'ha55a);
    core(1'b1, 1'b0, 24'h000011, 16'h0077);
    core(1'b0, 1'b1, 24'h000010, 16'h0);
    chk(q, 16'h775a);
    core(1'b0, 1'b0, 24'h000011, 16'h0);
    chk(q, 16'h0077);
    apb(1'b1, OFS_GCR, 32'h0c1);
    core(1'b0, 1'b1, 24'h000010, 16'h0);
    chk(oe_or, 24'h000fff);
    apb(1'b1, OFS_GCR, 32'h101);
  endtask : t_demux

  task automatic t_win;
    apb(1'b1, OFS_ASEL, 32'h10);
    apb(1'b1, OFS_FCFG + 8'h04, 32'h15);
    apb(1'b1, OFS_TCFG + 8'h04, 32'h451);
    core(1'b1, 1'b1, 24'h001020, 16'h1234);
    chk(ale_n, 2);
    lat_chk(20);
    chk(cs_and, 5'h1d);
    chk(oe_or, 24'h0);
    core(1'b0, 1'b1, 24'h001020, 16'h0);
    chk(q, 16'h1234);
    core(1'b0, 1'b1, 24'h008010, 16'h0);
    chk(q, 16'h775a);
    chk(ale_n, 1);
  endtask : t_win

  task automatic t_prio;
    apb(1'b1, OFS_ASEL + 8'h04, 32'h10);
    apb(1'b1, OFS_FCFG + 8'h08, 32'h13);
    apb(1'b1, OFS_TCFG + 8'h08, 32'h0);
    core(1'b0, 1'b1, 24'h001040, 16'h0);
    chk(cs_and, 5'h1b);
    apb(1'b1, OFS_ASEL + 8'h08, 32'h10);
    apb(1'b1, OFS_ASEL + 8'h0c, 32'h10);
    apb(1'b1, OFS_FCFG + 8'h0c, 32'h11);
    apb(1'b1, OFS_FCFG + 8'h10, 32'h13);
    apb(1'b1, OFS_TCFG + 8'h10, 32'h0);
    core(1'b0, 1'b1, 24'h001040, 16'h0);
    chk(cs_and, 5'h0f);
  endtask : t_prio

  task automatic t_ready;
    for (int p = 0; p < 2; p++) begin
      rdy_pol <= p[0];
      rdy_wait <= 4'h8;
      apb(1'b1, OFS_TCFG, 32'h1000 | (p << 13));
      core(1'b0, 1'b1, 24'h000010, 16'h0);
      chk(q, 16'h775a);
      chk(lat >= 16 && lat <= 30, 1);
    end
    rdy_wait <= 4'hf;
    apb(1'b1, OFS_TCFG, 32'h0);
    core(1'b0, 1'b1, 24'h000010, 16'h0);
    lat_chk(5);
    rdy_wait <= 4'h0;
  endtask : t_ready

  task automatic t_ipb;
    for (int k = 2; k < 5; k++) apb(1'b1, OFS_FCFG + 8'(4 * k), 32'h0);
    apb(1'b1, OFS_FCFG + 8'h04, 32'h19);
    apb(1'b1, OFS_TCFG + 8'h04, 32'h1000);
    core(1'b1, 1'b1, 24'h001022, 16'h4321);
    chk(ipb_a, 24'h001022);
    chk(ipb_w, 16'h4321);
    chk(ale_n, 0);
    core(1'b0, 1'b1, 24'h001022, 16'h0);
    chk(q, ipb_rdata);
  endtask : t_ipb

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_single();
    t_demux();
    t_win();
    t_prio();
    t_ready();
    t_ipb();
    chk(bad, 0);
    summarize();
  end
endmodule : ebc_ctrl_test
